// ==== logic/tic_consts.svh ====
// Offsets, field positions, reset values and timing counts of the interval timekeeper.
`ifndef TIC_CONSTS_SVH
`define TIC_CONSTS_SVH

`define TIC_ADDR_W 8
`define TIC_OFS_CTRL 8'h00
`define TIC_OFS_CMP 8'h04
`define TIC_OFS_SUB 8'h08
`define TIC_OFS_SEC 8'h0C
`define TIC_OFS_MIN 8'h10
`define TIC_OFS_HOUR 8'h14
`define TIC_OFS_ICNT 8'h18
`define TIC_OFS_IRQEN 8'h1C

`define TIC_BIT_TIME_CLOCK_ENABLE 0
`define TIC_BIT_INTERVAL_COUNT_ENABLE 1
`define TIC_BIT_FLAG 2
`define TIC_BIT_STI 3
`define TIC_BIT_TB_LO 4
`define TIC_BIT_TB_HI 5
`define TIC_BIT_TFH 6

`define TIC_CTRL_RESET 8'h00
`define TIC_SUB_MAX 7'h7F
`define TIC_SEC_MAX 6'h3B
`define TIC_MIN_MAX 6'h3B
`define TIC_HOUR24_MAX 8'h17
`define TIC_HOUR_FULL_MAX 8'hFF

`define TIC_CLK_PERIOD_NS 10
`define TIC_TICK_PERIOD_NS 7812500

`define TIC_RESP_OKAY 2'h0
`define TIC_RESP_SLVERR 2'h2

`endif

// ==== logic/tic_pkg.sv ====
// Types shared by the interval timekeeper modules.
package tic_pkg;
	typedef enum logic [1:0] {
		TIC_TB_SUB,
		TIC_TB_SEC,
		TIC_TB_MIN,
		TIC_TB_HOUR
	} tic_tbase_t;
endpackage

// ==== logic/tic_tick_div.sv ====
// Divider that turns the system clock into the 1/128 second tick.
`timescale 1ns/1ps
module tic_tick_div #(
	parameter int CYCLES = 781250
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	output logic tick
);
	logic [31:0] cnt_q;
	logic tick_q;
	wire atEnd = (cnt_q == 32'(CYCLES - 1));

	// Stopping restarts the phase so a fresh start gives a full first period.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= (!run || atEnd) ? 32'h0 : cnt_q + 32'h1;
			tick_q <= run && atEnd;
		end
	end

	assign tick = tick_q;
endmodule

// ==== logic/tic_axil_slave.sv ====
// AXI4-Lite slave front end that hands single register accesses to the timekeeper.
`timescale 1ns/1ps
`include "tic_consts.svh"
module tic_axil_slave import tic_pkg::*; #(
	parameter int AW = `TIC_ADDR_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic awvalid,
	output logic awready,
	input wire logic [AW-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [AW-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic wrEn,
	output logic [AW-1:0] wrAddr,
	output logic [7:0] wrData,
	input wire logic wrOk,
	output logic [AW-1:0] rdAddr,
	input wire logic [7:0] rdData,
	input wire logic rdOk
);
	logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
	logic [AW-1:0] awAddr_q;
	logic [7:0] wData_q;
	logic wLane0_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// Address and data may arrive in either order; each is parked until both are in.
	wire doWrite = awHeld_q && wHeld_q && !bvalid_q;
	// Nothing new is taken while a response waits, so at most one write is ever under way.
	wire awTake = awvalid && !awHeld_q && !bvalid_q;
	wire wTake = wvalid && !wHeld_q && !bvalid_q;
	wire arTake = arvalid && !rvalid_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= 8'h00;
			wLane0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `TIC_RESP_OKAY;
		end else begin
			awHeld_q <= doWrite ? 1'b0 : (awHeld_q || awTake);
			wHeld_q <= doWrite ? 1'b0 : (wHeld_q || wTake);
			if (awTake) awAddr_q <= awaddr;
			if (wTake) wData_q <= wdata[7:0];
			if (wTake) wLane0_q <= wstrb[0];
			bvalid_q <= doWrite ? 1'b1 : (bvalid_q && !bready);
			if (doWrite) bresp_q <= wrOk ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `TIC_RESP_OKAY;
		end else begin
			rvalid_q <= arTake ? 1'b1 : (rvalid_q && !rready);
			if (arTake) rdata_q <= {24'h0, rdData};
			if (arTake) rresp_q <= rdOk ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
		end
	end

	assign awready = !awHeld_q && !bvalid_q;
	assign wready = !wHeld_q && !bvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = !rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	// Only byte lane 0 carries register bits; a write without it changes nothing.
	assign wrEn = doWrite && wLane0_q;
	assign wrAddr = awAddr_q;
	assign wrData = wData_q;
	assign rdAddr = araddr;
endmodule

// ==== logic/tic_ctrl.sv ====
// Interval timekeeper: time-of-day counters, interval counter and their control register.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tic_consts.svh"
////////////////////////////////////////////////////////////////////////////////
module tic_ctrl import tic_pkg::*; #(
	parameter int TICK_CYCLES = `TIC_TICK_PERIOD_NS / `TIC_CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic porRst_b,
	input wire logic awvalid,
	output logic awready,
	input wire logic [`TIC_ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [`TIC_ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic intervalIrq
);
	////////////////////////////////////////////////////////////////////////////////
	// Register access.

	logic regWrEn;
	logic [`TIC_ADDR_W-1:0] regWrAddr;
	logic [7:0] regWrData;
	logic [`TIC_ADDR_W-1:0] regRdAddr;
	logic [7:0] regRdData;
	logic regWrOk;
	logic regRdOk;

	tic_axil_slave #(
		.AW(`TIC_ADDR_W)
	) u_bus (
		.clk(clk),
		.rst_b(rst_b),
		.awvalid(awvalid),
		.awready(awready),
		.awaddr(awaddr),
		.wvalid(wvalid),
		.wready(wready),
		.wdata(wdata),
		.wstrb(wstrb),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.araddr(araddr),
		.rvalid(rvalid),
		.rready(rready),
		.rdata(rdata),
		.rresp(rresp),
		.wrEn(regWrEn),
		.wrAddr(regWrAddr),
		.wrData(regWrData),
		.wrOk(regWrOk),
		.rdAddr(regRdAddr),
		.rdData(regRdData),
		.rdOk(regRdOk)
	);

	// Byte offsets inside a word are ignored; the word address selects.
	wire [`TIC_ADDR_W-1:0] wrWord = {regWrAddr[`TIC_ADDR_W-1:2], 2'b00};
	wire [`TIC_ADDR_W-1:0] rdWord = {regRdAddr[`TIC_ADDR_W-1:2], 2'b00};

	wire wrCtrl = regWrEn && (wrWord == `TIC_OFS_CTRL);
	wire wrCmp = regWrEn && (wrWord == `TIC_OFS_CMP);
	wire wrSub = regWrEn && (wrWord == `TIC_OFS_SUB);
	wire wrSec = regWrEn && (wrWord == `TIC_OFS_SEC);
	wire wrMin = regWrEn && (wrWord == `TIC_OFS_MIN);
	wire wrHour = regWrEn && (wrWord == `TIC_OFS_HOUR);
	wire wrIrqEn = regWrEn && (wrWord == `TIC_OFS_IRQEN);

	assign regWrOk = (wrWord == `TIC_OFS_CTRL) || (wrWord == `TIC_OFS_CMP) ||
		(wrWord == `TIC_OFS_SUB) || (wrWord == `TIC_OFS_SEC) ||
		(wrWord == `TIC_OFS_MIN) || (wrWord == `TIC_OFS_HOUR) ||
		(wrWord == `TIC_OFS_ICNT) || (wrWord == `TIC_OFS_IRQEN);

	////////////////////////////////////////////////////////////////////////////////
	// Control register state.

	logic twentyFour_q, twentyFour_d;
	logic [1:0] tbSel_q, tbSel_d;
	logic singleMode_q, singleMode_d;
	logic flag_q, flag_d;
	logic ivEnable_q, ivEnable_d;
	logic time_clock_enable_q, time_clock_enable_d;
	logic irqEn_q, irqEn_d;
	logic irq_q;
	logic [7:0] cmp_q, cmp_d;
	logic [6:0] sub_q, sub_d;
	logic [5:0] sec_q, sec_d;
	logic [5:0] min_q, min_d;
	logic [7:0] hour_q, hour_d;
	logic [7:0] ivCnt_q, ivCnt_d;
	logic subTick;
	tic_tbase_t tbase;

	////////////////////////////////////////////////////////////////////////////////
	// Timebase and time-of-day counters.

	// The divider shares the power-on reset so the tick phase is not lost across a device reset.
	tic_tick_div #(
		.CYCLES(TICK_CYCLES)
	) u_div (
		.clk(clk),
		.rst_b(porRst_b),
		.run(time_clock_enable_q),
		.tick(subTick)
	);

	wire subWrap = subTick && (sub_q == `TIC_SUB_MAX);
	wire secWrap = subWrap && (sec_q == `TIC_SEC_MAX);
	wire minWrap = secWrap && (min_q == `TIC_MIN_MAX);
	// An hour above 23 left over from the 256-hour range still wraps at the next hour carry.
	// wrap after 23
	wire hourLast = twentyFour_q ? (hour_q >= `TIC_HOUR24_MAX) : (hour_q == `TIC_HOUR_FULL_MAX);

	// clear on disable
	// Clearing wins over a same-cycle tick, so the time reads zero right after a stop.
	wire tcenFall = wrCtrl && time_clock_enable_q && !regWrData[`TIC_BIT_TIME_CLOCK_ENABLE];
	wire timeWrOk = !time_clock_enable_q;

	assign sub_d = tcenFall ? 7'h00 :
		(wrSub && timeWrOk) ? regWrData[6:0] :
		subWrap ? 7'h00 :
		subTick ? 7'(sub_q + 7'h01) : sub_q;

	assign sec_d = tcenFall ? 6'h00 :
		(wrSec && timeWrOk) ? regWrData[5:0] :
		secWrap ? 6'h00 :
		subWrap ? 6'(sec_q + 6'h01) : sec_q;

	assign min_d = tcenFall ? 6'h00 :
		(wrMin && timeWrOk) ? regWrData[5:0] :
		minWrap ? 6'h00 :
		secWrap ? 6'(min_q + 6'h01) : min_q;

	assign hour_d = tcenFall ? 8'h00 :
		(wrHour && timeWrOk) ? regWrData :
		(minWrap && hourLast) ? 8'h00 :
		minWrap ? 8'(hour_q + 8'h01) : hour_q;

	////////////////////////////////////////////////////////////////////////////////
	// Interval counter.

	assign tbase = tic_tbase_t'(tbSel_q);

	wire tbTick = (tbase == TIC_TB_SUB) ? subTick :
		(tbase == TIC_TB_SEC) ? subWrap :
		(tbase == TIC_TB_MIN) ? secWrap : minWrap;

	wire [7:0] ivCntInc = 8'(ivCnt_q + 8'h01);
	// match sets flag
	// Comparing the next value puts the match and the reload in the same cycle.
	wire ivMatch = ivEnable_q && tbTick && (ivCntInc == cmp_q);

	assign ivCnt_d = !ivEnable_q ? 8'h00 :
		ivMatch ? 8'h00 :
		tbTick ? ivCntInc : ivCnt_q;

	assign cmp_d = wrCmp ? regWrData : cmp_q;

	////////////////////////////////////////////////////////////////////////////////
	// Control field updates.

	assign twentyFour_d = wrCtrl ? regWrData[`TIC_BIT_TFH] : twentyFour_q;
	assign tbSel_d = wrCtrl ? regWrData[`TIC_BIT_TB_HI:`TIC_BIT_TB_LO] : tbSel_q;
	assign singleMode_d = wrCtrl ? regWrData[`TIC_BIT_STI] : singleMode_q;
	assign time_clock_enable_d = wrCtrl ? regWrData[`TIC_BIT_TIME_CLOCK_ENABLE] : time_clock_enable_q;
	assign irqEn_d = wrIrqEn ? regWrData[0] : irqEn_q;

	// single-shot disarm
	// A timeout in the same cycle as a software write still disarms the counter.
	assign ivEnable_d = (ivMatch && singleMode_q) ? 1'b0 :
		wrCtrl ? regWrData[`TIC_BIT_INTERVAL_COUNT_ENABLE] : ivEnable_q;

	// sticky until written clear
	// Writing a one keeps the flag; a match in the clearing cycle wins.
	assign flag_d = ivMatch || (flag_q && !(wrCtrl && !regWrData[`TIC_BIT_FLAG]));

	////////////////////////////////////////////////////////////////////////////////
	// Storage.

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			twentyFour_q <= 1'b0;
		end else begin
			twentyFour_q <= twentyFour_d;
		end
	end

	// survives device reset
	// Everything that keeps time stays on the power-on reset only, except the 24-hour bit twentyFour_q, which the device reset clears.
	always_ff @(posedge clk or negedge porRst_b) begin
		if (!porRst_b) begin
			time_clock_enable_q <= 1'b0;
		end else begin
			time_clock_enable_q <= time_clock_enable_d;
		end
	end

	always_ff @(posedge clk or negedge porRst_b) begin
		if (!porRst_b) begin
			sub_q <= 7'h00;
			sec_q <= 6'h00;
			min_q <= 6'h00;
			hour_q <= 8'h00;
		end else begin
			sub_q <= sub_d;
			sec_q <= sec_d;
			min_q <= min_d;
			hour_q <= hour_d;
		end
	end

	// The interval setup also stays on the power-on reset, so a device reset cannot lose a pending timeout.
	always_ff @(posedge clk or negedge porRst_b) begin
		if (!porRst_b) begin
			tbSel_q <= 2'h0;
			singleMode_q <= 1'b0;
			cmp_q <= 8'h00;
		end else begin
			tbSel_q <= tbSel_d;
			singleMode_q <= singleMode_d;
			cmp_q <= cmp_d;
		end
	end

	always_ff @(posedge clk or negedge porRst_b) begin
		if (!porRst_b) begin
			ivEnable_q <= 1'b0;
			ivCnt_q <= 8'h00;
		end else begin
			ivEnable_q <= ivEnable_d;
			ivCnt_q <= ivCnt_d;
		end
	end

	always_ff @(posedge clk or negedge porRst_b) begin
		if (!porRst_b) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irqEn_q <= 1'b0;
		end else begin
			irqEn_q <= irqEn_d;
		end
	end

	// request gated by enable
	// The request is registered, so it follows the flag one cycle late.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_q && irqEn_q;
		end
	end

	assign intervalIrq = irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// Read side.

	wire [7:0] ctrlRead = {1'b0, twentyFour_q, tbSel_q, singleMode_q, flag_q, ivEnable_q, time_clock_enable_q};

	wire rdCtrl = (rdWord == `TIC_OFS_CTRL);
	wire rdCmp = (rdWord == `TIC_OFS_CMP);
	wire rdSub = (rdWord == `TIC_OFS_SUB);
	wire rdSec = (rdWord == `TIC_OFS_SEC);
	wire rdMin = (rdWord == `TIC_OFS_MIN);
	wire rdHour = (rdWord == `TIC_OFS_HOUR);
	wire rdIcnt = (rdWord == `TIC_OFS_ICNT);
	wire rdIrqEn = (rdWord == `TIC_OFS_IRQEN);

	assign regRdOk = rdCtrl || rdCmp || rdSub || rdSec || rdMin || rdHour || rdIcnt || rdIrqEn;

	// Unmapped words read as zero alongside the error response.
	assign regRdData = rdCtrl ? ctrlRead :
		rdCmp ? cmp_q :
		rdSub ? {1'b0, sub_q} :
		rdSec ? {2'b00, sec_q} :
		rdMin ? {2'b00, min_q} :
		rdHour ? hour_q :
		rdIcnt ? ivCnt_q :
		rdIrqEn ? {7'h00, irqEn_q} : 8'h00;
endmodule

// ==== bench/tic_ctrl_asserts.sv ====
// Port-level assertions for the interval timekeeper.
`timescale 1ns/1ps
module tic_ctrl_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic porRst_b,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [7:0] araddr,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic intervalIrq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b || !porRst_b);
	write_answer_a: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
		else $error("write response late or early");
	write_refuse_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	write_close_a: assert property (bvalid && bready |=> !bvalid && awready)
		else $error("write response not closed");
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read data not one cycle after request");
	read_refuse_a: assert property (rvalid |-> !arready)
		else $error("read taken while data pending");
	ctrl_reserved_a: assert property (arvalid && arready && araddr[7:2] == 6'h00 |=> rdata[7] == 1'h0)
		else $error("control bit 7 read as one");
	unmapped_read_a: assert property (arvalid && arready && araddr >= 8'h20 |=> rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read not refused");
	// A flag clear needs a write, so the request stays up unless one was just sent.
	irq_hold_a: assert property (intervalIrq && !wvalid && !$past(wvalid) && !bvalid |=> intervalIrq)
		else $error("interrupt request dropped without a write");
endmodule

bind tic_ctrl tic_ctrl_chk i_chk (.clk, .rst_b, .porRst_b, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
	.arvalid, .arready, .araddr, .rvalid, .rdata, .rresp, .intervalIrq);

// ==== bench/testbench.sv ====
// Self-checking bench for the interval timekeeper.
`timescale 1ns/1ps
module testbench;
	localparam int TK = 4;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic porRst_b = 1'h0;
	logic awvalid = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic wvalid = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic arvalid = 1'h0;
	logic [7:0] araddr = 8'h00;
	logic awready, wready, bvalid, arready, rvalid, intervalIrq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [7:0] hp[3] = '{8'h17, 8'hFF, 8'h17};
	logic [7:0] he[3] = '{8'h18, 8'h00, 8'h00};
	logic tf[3] = '{1'h0, 1'h0, 1'h1};
	logic [7:0] c, r;
	int errors = 0;
	int check_count = 0;

	always #5 clk = ~clk;

	// Both answer readies stay high, so every answer closes in the cycle it appears.
	tic_ctrl #(.TICK_CYCLES(TK)) i_dut (.clk, .rst_b, .porRst_b, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb(4'hF), .bvalid, .bready(1'h1), .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready(1'h1), .rdata, .rresp, .intervalIrq);

	////////////////////////////////////////
	task automatic end_sim();
		$display("Checks %0d, errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cmp_rd(input logic [33:0] e, input logic [33:0] s);
		check_count++;
		if (e !== s) begin
			errors++;
			$display("[FAIL] read exp %h seen %h", e, s);
		end
	endtask

	task automatic cmp_wr(input logic [1:0] e, input logic [1:0] s);
		check_count++;
		if (e !== s) begin
			errors++;
			$display("[FAIL] wresp exp %h seen %h", e, s);
		end
	endtask

	// Outputs are sampled on the falling edge, where they have settled.
	task automatic tick(inout int n);
		@(negedge clk);
		n++;
		if (n > 300) begin
			errors++;
			end_sim();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
		int n;
		logic pa, pw;
		n = 0;
		pa = 1'h1;
		pw = 1'h1;
		bq.push_back(e);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (pa || pw) begin
			tick(n);
			pa = pa && !awready;
			pw = pw && !wready;
			@(posedge clk);
			awvalid <= pa;
			wvalid <= pw;
		end
		tick(n);
		while (bvalid !== 1'h1) tick(n);
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
		int n;
		n = 0;
		rq.push_back({e, 24'h0, d});
		araddr <= a;
		arvalid <= 1'h1;
		tick(n);
		while (arready !== 1'h1) tick(n);
		@(posedge clk);
		arvalid <= 1'h0;
		tick(n);
		while (rvalid !== 1'h1) tick(n);
		@(posedge clk);
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		tick(n);
		while (intervalIrq !== 1'h1) tick(n);
		@(posedge clk);
	endtask

	////////////////////////////////////////
	always @(negedge clk) begin
		if (rvalid === 1'h1) cmp_rd(rq.pop_front(), {rresp, rdata});
		if (bvalid === 1'h1) cmp_wr(bq.pop_front(), bresp);
	end

	initial begin
		void'($urandom(32'h76D1));
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		porRst_b <= 1'h1;
		@(posedge clk);
		rd(8'h00, 8'h00);
		rd(8'h20, 8'h00, 2'h2);
		wr(8'h20, 8'h55, 2'h2);
		wr(8'h00, 8'h80);
		rd(8'h00, 8'h00);
		r = 8'($urandom);
		wr(8'h04, r);
		rd(8'h04, r);
		for (int i = 0; i < 3; i++) begin
			wr(8'h00, 8'h00);
			rd(8'h14, 8'h00);
			wr(8'h08, 8'h7F);
			wr(8'h0C, 8'h3B);
			wr(8'h10, 8'h3B);
			wr(8'h14, hp[i]);
			wr(8'h00, {1'h0, tf[i], 6'h01});
			repeat (TK + 2) @(posedge clk);
			rd(8'h14, he[i]);
			rd(8'h10, 8'h00);
			rd(8'h0C, 8'h00);
			wr(8'h0C, 8'h05);
			rd(8'h0C, 8'h00);
		end
		rst_b <= 1'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		rd(8'h00, 8'h01);
		wr(8'h00, 8'h41);
		rd(8'h00, 8'h41);
		wr(8'h1C, 8'h01);
		// Preloads make every counter faster than the chosen timebase, but no other, roll over on the first tick, so the chosen timebase ticks.
		for (int t = 0; t < 4; t++) begin
			c = {2'h1, 2'(t), 4'hB};
			wr(8'h00, 8'h40);
			wr(8'h08, (t > 0) ? 8'h7F : 8'h00);
			wr(8'h0C, (t > 1) ? 8'h3B : 8'h00);
			wr(8'h10, (t > 2) ? 8'h3B : 8'h00);
			wr(8'h04, 8'h01);
			wr(8'h00, c);
			wait_irq();
			rd(8'h00, c ^ 8'h06);
			rd(8'h18, 8'h00);
			repeat (20) @(posedge clk);
			rd(8'h00, c ^ 8'h06);
		end
		r = 8'($urandom_range(2, 6));
		wr(8'h00, 8'h40);
		wr(8'h04, r);
		wr(8'h00, 8'h43);
		wait_irq();
		rd(8'h00, 8'h47);
		wr(8'h00, 8'h45);
		rd(8'h00, 8'h45);
		rd(8'h18, 8'h00);
		wr(8'h00, 8'h41);
		rd(8'h00, 8'h41);
		end_sim();
	end
endmodule
